// *** inc/shadow_port_pkg.sv ***
// constants and types shared by the shadow data port design
package shadow_port_pkg;
  // ****************************************
  // register map (word byte addresses)
  // ****************************************
  localparam logic [31:0] SHADOW_BASE = 32'h5000_1030;
  localparam int SHADOW_COUNT = 16;
  localparam logic [31:0] SHADOW_DATA_4 = 32'h5000_1040;
  localparam logic [31:0] SHADOW_DATA_5 = 32'h5000_1044;
  localparam logic [31:0] LINE_STATE_ADDR = 32'h5000_1080;
  localparam logic [31:0] FIFO_SETUP_ADDR = 32'h5000_1084;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h5000_1088;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h5000_108C;
  // ****************************************
  // field positions
  // ****************************************
  localparam int LS_DATA_VALID = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_TX_EMPTY = 5;
  localparam int FS_FIFO_EN = 0;
  localparam int FS_IR_MODE = 1;
  localparam int EV_RX_DATA = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_TX_EMPTY = 2;
  localparam int EV_TX_LOST = 3;
  localparam int EV_WIDTH = 4;
  // ****************************************
  // reset values and depths
  // ****************************************
  localparam logic [7:0] SHADOW_RESET = 8'h00;
  localparam logic [1:0] FIFO_SETUP_RESET = 2'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam int FIFO_DEPTH_DEFAULT = 16;
  // ****************************************
  // transmit state
  // ****************************************
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;
endpackage

// *** logic/shadow_fifo.sv ***
// byte fifo with registered head output
`timescale 1ns/1ps
module shadow_fifo
  import shadow_port_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEFAULT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic push,
  input wire logic [7:0] pushData,
  input wire logic pop,
  output logic [7:0] headData,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_badDepth
    $error("fifo depth must be a power of two");
  end
  logic [7:0] mem [DEPTH];
  logic [AW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [7:0] head_r;
  logic doPush, doPop;
  assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  assign empty = wrPtr_r == rdPtr_r;
  assign doPush = push && !full;
  assign doPop = pop && !empty;
  assign headData = head_r;
  always_comb begin
    wrPtr_nxt = wrPtr_r + (AW + 1)'(doPush);
    rdPtr_nxt = rdPtr_r + (AW + 1)'(doPop);
    if (flush) begin
      wrPtr_nxt = '0;
      rdPtr_nxt = '0;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_r[AW-1:0]] <= pushData;
    end
  end
  // head register follows the read pointer, bypassing a write into an empty fifo
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      head_r <= SHADOW_RESET;
    end else if (doPush && (wrPtr_r[AW-1:0] == rdPtr_nxt[AW-1:0]) && (wrPtr_r == rdPtr_nxt)) begin
      head_r <= pushData;
    end else begin
      head_r <= mem[rdPtr_nxt[AW-1:0]];
    end
  end
endmodule

// *** logic/shadow_serial_tx.sv ***
// serializer for one 8n1 character per load
`timescale 1ns/1ps
module shadow_serial_tx
  import shadow_port_pkg::*;
#(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [7:0] loadData,
  output logic busy,
  output logic lineOut
);
  if (BIT_CYCLES < 1 || BIT_CYCLES > 65536) begin : g_badBit
    $error("bit time must be 1 to 65536 cycles");
  end
  tx_state_t state_r, state_nxt;
  logic [9:0] shift_r, shift_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [15:0] tick_r, tick_nxt;
  assign busy = state_r == TX_SEND;
  assign lineOut = shift_r[0];
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bitCnt_nxt = bitCnt_r;
    tick_nxt = tick_r;
    case (state_r)
      TX_IDLE: begin
        if (load) begin
          shift_nxt = {1'b1, loadData, 1'b0};
          bitCnt_nxt = 4'h0;
          tick_nxt = 16'h0000;
          state_nxt = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tick_r == 16'(BIT_CYCLES - 1)) begin
          tick_nxt = 16'h0000;
          shift_nxt = {1'b1, shift_r[9:1]};
          bitCnt_nxt = bitCnt_r + 4'h1;
          if (bitCnt_r == 4'h9) state_nxt = TX_IDLE;
        end else begin
          tick_nxt = tick_r + 16'h0001;
        end
      end
      default: state_nxt = TX_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= TX_IDLE;
      shift_r <= 10'h3FF;
      bitCnt_r <= 4'h0;
      tick_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      bitCnt_r <= bitCnt_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

// *** logic/uart_shadow_data_port.sv ***
// shadow data port: receive buffer and transmit holding aliases with fifos
//
// Behaviour
// - sixteen word aliases reach rx and tx data
// - read returns byte from serial or infrared input
// - read data valid only while data-valid flag set
// - fifo off: new byte overwrites, overrun flagged
// - fifo on: read returns receive fifo head
// - full receive fifo drops new byte, overrun; code flags no overrun if a read pops the fifo in the same cycle
// - written byte sent on serial or infrared out
// - fifo off: write clears holding-empty flag
// - fifo off: extra write overwrites pending byte
// - fifo on: accepts up to depth characters
// - write to full transmit fifo is discarded
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module uart_shadow_data_port
  import shadow_port_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT,
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [31:0] busRdData,
  input wire logic rxValid,
  input wire logic [7:0] rxSerialByte,
  input wire logic [7:0] rxInfraredByte,
  output logic serialOut,
  output logic infraredOut_n,
  output logic irq
);
  // ****************************************
  // parameter checks
  // ****************************************
  if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_badDepth
    $error("fifo depth must be a power of two, two or more");
  end
  if (BIT_CYCLES < 1 || BIT_CYCLES > 65536) begin : g_badBit
    $error("bit time must be 1 to 65536 cycles");
  end
  // ****************************************
  // address decode
  // ****************************************
  function automatic logic isShadow(input logic [31:0] a);
    logic [31:0] off;
    off = a - SHADOW_BASE;
    return (a[1:0] == 2'b00) && (a >= SHADOW_BASE) && (off < 32'(SHADOW_COUNT * 4));
  endfunction
  logic shadowWr, shadowRd;
  assign shadowWr = busWrite && isShadow(busAddr);
  assign shadowRd = busRead && isShadow(busAddr);
  function automatic logic hitReg(input logic strobe, input logic [31:0] a,
    input logic [31:0] target);
    return strobe && (a == target);
  endfunction
  logic wrSetup, wrMask, wrStatus, rdLine;
  assign wrSetup = hitReg(busWrite, busAddr, FIFO_SETUP_ADDR);
  assign wrMask = hitReg(busWrite, busAddr, IRQ_MASK_ADDR);
  assign wrStatus = hitReg(busWrite, busAddr, IRQ_STATUS_ADDR);
  assign rdLine = hitReg(busRead, busAddr, LINE_STATE_ADDR);
  // ****************************************
  // configuration
  // ****************************************
  logic [1:0] fifoSetup_r, fifoSetup_nxt;
  logic [3:0] irqMask_r, irqMask_nxt;
  logic fifoOn, irMode, modeChange;
  assign fifoOn = fifoSetup_r[FS_FIFO_EN];
  assign irMode = fifoSetup_r[FS_IR_MODE];
  assign modeChange = wrSetup && busWrData[FS_FIFO_EN] != fifoOn;
  always_comb begin
    fifoSetup_nxt = fifoSetup_r;
    irqMask_nxt = irqMask_r;
    if (wrSetup) fifoSetup_nxt = busWrData[1:0];
    if (wrMask) irqMask_nxt = busWrData[3:0];
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fifoSetup_r <= FIFO_SETUP_RESET;
      irqMask_r <= IRQ_MASK_RESET;
    end else begin
      fifoSetup_r <= fifoSetup_nxt;
      irqMask_r <= irqMask_nxt;
    end
  end
  // ****************************************
  // receive path
  // ****************************************
  logic [7:0] rxByte;
  logic [7:0] rxHold_r, rxHold_nxt;
  logic rxHoldValid_r, rxHoldValid_nxt;
  logic overrun_r, overrun_nxt;
  logic rxFull, rxEmpty, rxPush, rxPop;
  logic [7:0] rxHead;
  logic dataValid, overrunEvent;
  assign rxByte = irMode ? rxInfraredByte : rxSerialByte;
  assign rxPush = fifoOn && rxValid;
  assign rxPop = fifoOn && shadowRd;
  shadow_fifo #(.DEPTH(FIFO_DEPTH)) rxFifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(modeChange),
    .push(rxPush),
    .pushData(rxByte),
    .pop(rxPop),
    .headData(rxHead),
    .full(rxFull),
    .empty(rxEmpty)
  );
  assign dataValid = fifoOn ? !rxEmpty : rxHoldValid_r;
  assign overrunEvent = rxValid && (fifoOn ? (rxFull && !rxPop)
    : (rxHoldValid_r && !shadowRd));
  always_comb begin
    rxHold_nxt = rxHold_r;
    rxHoldValid_nxt = rxHoldValid_r;
    overrun_nxt = overrun_r;
    if (!fifoOn && shadowRd) rxHoldValid_nxt = 1'b0;
    if (!fifoOn && rxValid) begin
      rxHold_nxt = rxByte;
      rxHoldValid_nxt = 1'b1;
    end
    if (rdLine) overrun_nxt = 1'b0;
    if (overrunEvent) overrun_nxt = 1'b1;
    if (modeChange) rxHoldValid_nxt = 1'b0;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxHold_r <= SHADOW_RESET;
      rxHoldValid_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      rxHold_r <= rxHold_nxt;
      rxHoldValid_r <= rxHoldValid_nxt;
      overrun_r <= overrun_nxt;
    end
  end
  // ****************************************
  // transmit path
  // ****************************************
  logic [7:0] txHold_r, txHold_nxt;
  logic txHoldFull_r, txHoldFull_nxt;
  logic txFull, txEmpty, txPush, txPop, txLoad, txBusy, txLine;
  logic [7:0] txHead, txLoadData;
  logic txHoldEmpty, txLost;
  assign txPush = fifoOn && shadowWr;
  assign txLost = fifoOn && shadowWr && txFull;
  assign txLoad = !txBusy && (fifoOn ? !txEmpty : txHoldFull_r);
  assign txPop = fifoOn && txLoad;
  assign txLoadData = fifoOn ? txHead : txHold_r;
  shadow_fifo #(.DEPTH(FIFO_DEPTH)) txFifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(modeChange),
    .push(txPush),
    .pushData(busWrData[7:0]),
    .pop(txPop),
    .headData(txHead),
    .full(txFull),
    .empty(txEmpty)
  );
  shadow_serial_tx #(.BIT_CYCLES(BIT_CYCLES)) txSer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(txLoad),
    .loadData(txLoadData),
    .busy(txBusy),
    .lineOut(txLine)
  );
  assign txHoldEmpty = fifoOn ? txEmpty : !txHoldFull_r;
  always_comb begin
    txHold_nxt = txHold_r;
    txHoldFull_nxt = txHoldFull_r;
    if (!fifoOn && txLoad) txHoldFull_nxt = 1'b0;
    if (!fifoOn && shadowWr) begin
      txHold_nxt = busWrData[7:0];
      txHoldFull_nxt = 1'b1;
    end
    if (modeChange) txHoldFull_nxt = 1'b0;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txHold_r <= SHADOW_RESET;
      txHoldFull_r <= 1'b0;
      serialOut <= 1'b1;
      infraredOut_n <= 1'b1;
    end else begin
      txHold_r <= txHold_nxt;
      txHoldFull_r <= txHoldFull_nxt;
      serialOut <= irMode ? 1'b1 : txLine;
      infraredOut_n <= irMode ? txLine : 1'b1;
    end
  end
  // ****************************************
  // interrupts
  // ****************************************
  logic [3:0] irqStatus_r, irqStatus_nxt, events;
  logic txEmptyPrev_r;
  always_comb begin
    events = 4'h0;
    events[EV_RX_DATA] = rxValid;
    events[EV_OVERRUN] = overrunEvent;
    events[EV_TX_EMPTY] = txHoldEmpty && !txEmptyPrev_r;
    events[EV_TX_LOST] = txLost;
    irqStatus_nxt = irqStatus_r;
    if (wrStatus) irqStatus_nxt = irqStatus_r & ~busWrData[3:0];
    irqStatus_nxt = irqStatus_nxt | events;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStatus_r <= 4'h0;
      txEmptyPrev_r <= 1'b1;
      irq <= 1'b0;
    end else begin
      irqStatus_r <= irqStatus_nxt;
      txEmptyPrev_r <= txHoldEmpty;
      irq <= |(irqStatus_nxt & irqMask_nxt);
    end
  end
  // ****************************************
  // read data
  // ****************************************
  logic [31:0] rdData_nxt;
  always_comb begin
    rdData_nxt = 32'h0000_0000;
    if (shadowRd) begin
      rdData_nxt = {24'h00_0000, fifoOn ? rxHead : rxHold_r};
    end else if (busRead) begin
      case (busAddr)
        LINE_STATE_ADDR: begin
          rdData_nxt[LS_DATA_VALID] = dataValid;
          rdData_nxt[LS_OVERRUN] = overrun_r;
          rdData_nxt[LS_TX_EMPTY] = txHoldEmpty;
        end
        FIFO_SETUP_ADDR: rdData_nxt = {30'h0, fifoSetup_r};
        IRQ_STATUS_ADDR: rdData_nxt = {28'h000_0000, irqStatus_r};
        IRQ_MASK_ADDR: rdData_nxt = {28'h000_0000, irqMask_r};
        default: rdData_nxt = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) busRdData <= 32'h0000_0000;
    else busRdData <= rdData_nxt;
  end
  // ****************************************
  // checks
  // ****************************************
  shadow_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    !fifoOn && shadowWr && !modeChange |=> !txHoldEmpty)
    else $error("holding-empty flag not cleared by write");
  hold_overwrite_a: assert property (@(posedge clk) disable iff (sys_rst)
    !fifoOn && shadowWr |=> txHold_r == $past(busWrData[7:0]))
    else $error("holding data not overwritten");
  rx_overwrite_a: assert property (@(posedge clk) disable iff (sys_rst)
    !fifoOn && rxValid && rxHoldValid_r && !shadowRd |=> overrun_r && rxHold_r == $past(rxByte))
    else $error("overrun not flagged on overwrite");
  rx_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
    fifoOn && rxValid && rxFull && !rxPop |=> overrun_r && rxFull)
    else $error("full fifo overrun not flagged");
  tx_lost_a: assert property (@(posedge clk) disable iff (sys_rst)
    txLost && !txPop |=> irqStatus_r[EV_TX_LOST] && txFull)
    else $error("lost write not reported");
  upper_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    shadowRd |=> busRdData[31:8] == 24'h00_0000)
    else $error("reserved bits not zero");
  shadow_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    shadowRd && fifoOn |=> busRdData[7:0] == $past(rxHead))
    else $error("fifo head not returned");
  ir_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    irMode ##1 irMode |-> serialOut && infraredOut_n == $past(txLine))
    else $error("infrared output routing wrong");
  alias_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
    busRead && busAddr == SHADOW_DATA_5 && !fifoOn |=> busRdData[7:0] == $past(rxHold_r))
    else $error("alias read wrong");
  irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 irq == |(irqStatus_r & irqMask_r))
    else $error("interrupt level wrong");
  rx_valid_a: assert property (@(posedge clk) disable iff (sys_rst)
    !fifoOn && rxValid && !modeChange |=> dataValid)
    else $error("data-valid flag not set by arrival");
  rx_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    !fifoOn && shadowRd && !rxValid |=> !dataValid)
    else $error("data-valid flag not cleared by read");
  rx_source_a: assert property (@(posedge clk) disable iff (sys_rst)
    !fifoOn && rxValid |=> rxHold_r ==
    ($past(irMode) ? $past(rxInfraredByte) : $past(rxSerialByte)))
    else $error("receive byte taken from wrong input");
  tx_accept_a: assert property (@(posedge clk) disable iff (sys_rst)
    fifoOn && shadowWr && !txFull && !modeChange |=> !txEmpty)
    else $error("write not accepted by transmit fifo");
  normal_out_a: assert property (@(posedge clk) disable iff (sys_rst)
    !irMode ##1 !irMode |-> infraredOut_n && serialOut == $past(txLine))
    else $error("serial output routing wrong");
  reset_state_a: assert property (@(posedge clk)
    sys_rst |=> serialOut && infraredOut_n && !irq && busRdData == 32'h0000_0000)
    else $error("outputs not at reset values");
  fifo_flush_a: assert property (@(posedge clk) disable iff (sys_rst)
    modeChange |=> rxEmpty && txEmpty && !rxHoldValid_r && !txHoldFull_r)
    else $error("mode change did not flush");
  rx_event_a: assert property (@(posedge clk) disable iff (sys_rst)
    rxValid |=> irqStatus_r[EV_RX_DATA])
    else $error("receive event not recorded");
  overrun_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    overrunEvent |=> irqStatus_r[EV_OVERRUN] && overrun_r)
    else $error("overrun event not recorded");
  overrun_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    rdLine && !overrunEvent |=> !overrun_r)
    else $error("overrun not cleared by line state read");
  tx_event_a: assert property (@(posedge clk) disable iff (sys_rst)
    txHoldEmpty && !txEmptyPrev_r |=> irqStatus_r[EV_TX_EMPTY])
    else $error("holding-empty event not recorded");
  rx_over_c: cover property (@(posedge clk) disable iff (sys_rst) overrunEvent);
  tx_full_c: cover property (@(posedge clk) disable iff (sys_rst) txLost);
  ir_send_c: cover property (@(posedge clk) disable iff (sys_rst) irMode && txLoad);
  fifo_read_c: cover property (@(posedge clk) disable iff (sys_rst) fifoOn && shadowRd);
endmodule

// *** testbench/uart_far_end.sv ***
// far-end serial partner: presents received characters and decodes the tx line
`timescale 1ns/1ps
module uart_far_end #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic clk,
  input wire logic irMode,
  input wire logic serialOut,
  output logic rxValid,
  output logic [7:0] rxSerialByte,
  output logic [7:0] rxInfraredByte
);
  logic [7:0] got[$];
  logic [7:0] b;
  initial begin
    rxValid = 1'b0;
    rxSerialByte = 8'h00;
    rxInfraredByte = 8'h00;
  end
  // ****************************************
  // receive side: one character per call
  // ****************************************
  task automatic send(input logic [7:0] d);
    @(posedge clk);
    rxValid <= 1'b1;
    rxSerialByte <= irMode ? ~d : d;
    rxInfraredByte <= irMode ? d : ~d;
    @(posedge clk);
    rxValid <= 1'b0;
    rxSerialByte <= ~rxSerialByte;
    rxInfraredByte <= ~rxInfraredByte;
  endtask
  // ****************************************
  // transmit side: 8n1 decode, lsb first
  // ****************************************
  initial forever begin
    @(negedge serialOut);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      b[i] = serialOut;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    if (serialOut === 1'b1) got.push_back(b);
  end
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the shadow data port
`timescale 1ns/1ps
module testbench;
  import shadow_port_pkg::*;
  localparam int DEPTH = 4;
  localparam int BITC = 4;
  typedef struct {logic [31:0] addr; logic [7:0] data;} row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] busAddr = 32'h0;
  logic [31:0] busWrData = 32'h0;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic [31:0] busRdData;
  logic rxValid;
  logic [7:0] rxSerialByte;
  logic [7:0] rxInfraredByte;
  logic serialOut;
  logic infraredOut_n;
  logic irq;
  logic irMode = 1'b0;
  logic [31:0] rd;
  logic [31:0] seenLow;
  logic [31:0] bad;
  int n_errors = 0;
  int comparisons = 0;
  row_t rows[4] = '{'{SHADOW_BASE, 8'h5A}, '{SHADOW_DATA_4, 8'hA5},
    '{SHADOW_DATA_5, 8'h01}, '{SHADOW_BASE + 32'h3C, 8'hFF}};
  always #50 clk = ~clk;
  uart_shadow_data_port #(.FIFO_DEPTH(DEPTH), .BIT_CYCLES(BITC)) u_uart_shadow_data_port (
    .clk(clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWrData(busWrData),
    .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData), .rxValid(rxValid),
    .rxSerialByte(rxSerialByte), .rxInfraredByte(rxInfraredByte), .serialOut(serialOut),
    .infraredOut_n(infraredOut_n), .irq(irq));
  uart_far_end #(.BIT_CYCLES(BITC)) u_uart_far_end (
    .clk(clk), .irMode(irMode), .serialOut(serialOut), .rxValid(rxValid),
    .rxSerialByte(rxSerialByte), .rxInfraredByte(rxInfraredByte));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    busWrite <= 1'b1;
    busAddr <= a;
    busWrData <= d;
    @(posedge clk);
    busWrite <= 1'b0;
  endtask
  task automatic rdr(input logic [31:0] a);
    @(posedge clk);
    busRead <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busRead <= 1'b0;
    #1 rd = busRdData;
  endtask
  task automatic lsChk(input logic [31:0] mask, input logic [31:0] exp);
    rdr(LINE_STATE_ADDR);
    chk("lineState", rd & mask, exp);
  endtask
  task automatic waitGot(input int n);
    for (int i = 0; i < 3000 && u_uart_far_end.got.size() < n; i++) @(posedge clk);
    if (u_uart_far_end.got.size() < n) begin
      n_errors++;
      $display("[ERR] txCount expected %0d seen %0d", n, u_uart_far_end.got.size());
      finish_test();
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rdr(SHADOW_DATA_4);
    chk("shadowReset", rd, 32'h0);
    lsChk(32'h23, 32'h20);
    rdr(SHADOW_BASE - 32'h4);
    chk("unmapped", rd, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      u_uart_far_end.send(rows[i].data);
      lsChk(32'h1, 32'h1);
      rdr(rows[i].addr);
      chk("rxByte", rd, {24'h0, rows[i].data});
      lsChk(32'h1, 32'h0);
    end
    $display("row test done");
    wr(IRQ_STATUS_ADDR, 32'hF);
    wr(IRQ_MASK_ADDR, 32'h1);
    u_uart_far_end.send(8'h11);
    repeat (2) @(posedge clk);
    #1 chk("irqOn", {31'h0, irq}, 32'h1);
    wr(IRQ_MASK_ADDR, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("irqMasked", {31'h0, irq}, 32'h0);
    wr(IRQ_STATUS_ADDR, 32'h1);
    rdr(IRQ_STATUS_ADDR);
    chk("irqCleared", rd & 32'h1, 32'h0);
    $display("interrupt test done");
    u_uart_far_end.send(8'h22);
    u_uart_far_end.send(8'h33);
    lsChk(32'h3, 32'h3);
    rdr(SHADOW_DATA_4);
    chk("overwrite", rd, 32'h33);
    $display("overrun test done");
    irMode = 1'b1;
    wr(FIFO_SETUP_ADDR, 32'h2);
    u_uart_far_end.send(8'hC3);
    rdr(SHADOW_DATA_5);
    chk("irByte", rd, 32'hC3);
    seenLow = 32'h0;
    bad = 32'h0;
    wr(SHADOW_DATA_4, 32'hFFFF_FF96);
    repeat (200) begin
      @(posedge clk);
      if (infraredOut_n === 1'b0) seenLow = 32'h1;
      if (serialOut !== 1'b1) bad = 32'h1;
    end
    chk("irPulse", seenLow, 32'h1);
    chk("serialIdle", bad, 32'h0);
    $display("infrared test done");
    irMode = 1'b0;
    wr(FIFO_SETUP_ADDR, 32'h0);
    lsChk(32'h20, 32'h20);
    wr(SHADOW_DATA_4, 32'hAB00_0041);
    repeat (4) @(posedge clk);
    wr(SHADOW_DATA_4, 32'h42);
    lsChk(32'h20, 32'h0);
    wr(SHADOW_DATA_4, 32'h43);
    waitGot(2);
    repeat (80) @(posedge clk);
    chk("txFirst", u_uart_far_end.got[0], 32'h41);
    chk("txOverwrite", u_uart_far_end.got[1], 32'h43);
    chk("txCount", 32'(u_uart_far_end.got.size()), 32'h2);
    u_uart_far_end.got.delete();
    $display("holding test done");
    wr(FIFO_SETUP_ADDR, 32'h1);
    for (int i = 0; i <= DEPTH; i++) u_uart_far_end.send(8'h60 + 8'(i));
    lsChk(32'h3, 32'h3);
    for (int i = 0; i < DEPTH; i++) begin
      rdr(SHADOW_BASE + 32'(4 * i));
      chk("fifoHead", rd, 32'h60 + 32'(i));
    end
    lsChk(32'h1, 32'h0);
    wr(IRQ_STATUS_ADDR, 32'hF);
    for (int i = 0; i < DEPTH + 2; i++) wr(SHADOW_DATA_5, 32'h70 + 32'(i));
    rdr(IRQ_STATUS_ADDR);
    chk("txLost", rd & 32'h8, 32'h8);
    waitGot(DEPTH);
    repeat (300) @(posedge clk);
    for (int i = 0; i < DEPTH; i++) begin
      chk("txFifo", u_uart_far_end.got[i], 32'h70 + 32'(i));
    end
    chk("txKept", 32'(u_uart_far_end.got.size()), 32'(DEPTH + 1));
    chk("txLastKept", u_uart_far_end.got[DEPTH], 32'h70 + 32'(DEPTH));
    $display("fifo test done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    lsChk(32'h23, 32'h20);
    rdr(FIFO_SETUP_ADDR);
    chk("setupReset", rd & 32'h3, 32'h0);
    $display("second reset test done");
    finish_test();
  end
endmodule
